//--- design/qdl_defines.vh
// Constants and register map of the quad DAC serial host loader
// Contract
// - The host drives frame sync low before shifting a word and keeps it low for the whole word.
// - Each data bit is stable at the falling serial clock edge, where the device samples it.
// - In byte mode frame sync stays low after the first byte and a second byte completes the word.
// - After the second byte has been shifted the host returns frame sync high to end the frame.
// - Bits go out most significant first, so an LSB-first source is bit-reversed before sending.
// - The host pulses load low after each word, or after all four channels are loaded.
// - A synchronous serial port uses polarity 0 and phase 1: clock idles low, data valid at fall.
// - A DSP-style host may send one 16-bit word with frame low, data changing on rising edges.
// - In word mode frame falls while the clock is high or rising, then MSB first on rising edges.
// - After all sixteen bits the host may drive load low to update the outputs.
`ifndef QDL_DEFINES_VH
`define QDL_DEFINES_VH

// Register offsets
`define QDL_REG_DATA     4'h0
`define QDL_REG_CTRL     4'h1
`define QDL_REG_STATUS   4'h2
`define QDL_REG_DIV      4'h3
`define QDL_REG_STROBE   4'h4

// Data register fields
`define QDL_ADDR_HI      3
`define QDL_ADDR_LO      2
`define QDL_CHAN_HI      1
`define QDL_CHAN_LO      0

// Control register fields
`define QDL_CTRL_WORD_MODE  0
`define QDL_CTRL_AUTO_LOAD  1
`define QDL_CTRL_LSB_SRC    2

// Strobe register fields
`define QDL_STB_LOAD     0
`define QDL_STB_CLEAR    1

// Status register fields
`define QDL_STAT_BUSY    0
`define QDL_STAT_LOADN   1
`define QDL_STAT_CLRN    2

// Reset values
`define QDL_CTRL_RST     3'h0
`define QDL_DIV_RST      8'h03

// Timing counts
`define QDL_WORD_BITS    5'h10
`define QDL_BYTE_BITS    5'h08
`define QDL_STROBE_CYC   8'h08
`define QDL_GAP_CYC      8'h04

`endif

//--- design/qdl_host_loader.v
// Host controller that shifts 16-bit words into a quad DAC and drives its strobes
`timescale 1ns/1ps
`include "qdl_defines.vh"

module qdl_host_loader (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	// Register port
	input  wire [3:0]  reg_addr,
	input  wire [15:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [15:0] reg_rdata,
	// Device pins
	output reg         frame_sync_n,
	output reg         serial_clock_input,
	output reg         serial_data_input,
	output reg         load_outputs_n,
	output reg         clear_outputs_n
);

	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_LOW   = 3'h2;
	localparam [2:0] ST_HIGH  = 3'h3;
	localparam [2:0] ST_GAP   = 3'h4;
	localparam [2:0] ST_DONE  = 3'h5;
	localparam [2:0] ST_LOAD  = 3'h6;

	reg [2:0]  state_ff;
	reg [15:0] shift_ff;
	reg [4:0]  bit_cnt_ff;
	reg [7:0]  div_ff;
	reg [7:0]  tick_cnt_ff;
	reg [2:0]  ctrl_ff;
	reg [7:0]  hold_cnt_ff;
	reg        clr_hold_ff;
	reg        pend_ff;
	reg [15:0] pend_word_ff;
	reg        busy_ff;
	reg [7:0]  clr_cnt_ff;

	// Byte bit reversal for LSB-first sources
	function [7:0] rev8;
		input [7:0] b;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				rev8[i] = b[7 - i];
			end
		end
	endfunction

	wire        tick     = (tick_cnt_ff == 8'h00);
	wire        wr_data  = reg_wr && (reg_addr == `QDL_REG_DATA);
	wire [15:0] src_word = ctrl_ff[`QDL_CTRL_LSB_SRC] ?
		{rev8(reg_wdata[15:8]), rev8(reg_wdata[7:0])} : reg_wdata;

	// Register writes and reads
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_ff   <= `QDL_CTRL_RST;
			div_ff    <= `QDL_DIV_RST;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == `QDL_REG_CTRL) begin
				ctrl_ff <= reg_wdata[2:0];
			end
			if (reg_wr && reg_addr == `QDL_REG_DIV && reg_wdata[7:0] != 8'h00) begin
				div_ff <= reg_wdata[7:0];
			end
			if (reg_rd) begin
				case (reg_addr)
				`QDL_REG_CTRL:   reg_rdata <= {13'h0000, ctrl_ff};
				`QDL_REG_STATUS: reg_rdata <= {13'h0000, clear_outputs_n, load_outputs_n,
					busy_ff};
				`QDL_REG_DIV:    reg_rdata <= {8'h00, div_ff};
				default:         reg_rdata <= 16'h0000;
				endcase
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// Clear strobe, held low for the divider count plus one cycle, released early once the sequencer leaves idle
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			clear_outputs_n <= 1'b1;
			clr_hold_ff     <= 1'b0;
			clr_cnt_ff      <= 8'h00;
		end else if (reg_wr && reg_addr == `QDL_REG_STROBE &&
			reg_wdata[`QDL_STB_CLEAR]) begin
			clear_outputs_n <= 1'b0;
			clr_hold_ff     <= 1'b1;
			clr_cnt_ff      <= div_ff;
		end else if (clr_hold_ff && (clr_cnt_ff == 8'h00 || state_ff != ST_IDLE)) begin
			// Idle divider is parked, so the clear pulse keeps its own count
			clear_outputs_n <= 1'b1;
			clr_hold_ff     <= 1'b0;
		end else if (clr_hold_ff) begin
			clr_cnt_ff <= clr_cnt_ff - 8'h01;
		end
	end

	// Serial clock divider, one-cycle enable per sequencer step, three steps per bit
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_cnt_ff <= 8'h00;
		end else if (tick || state_ff == ST_IDLE) begin
			tick_cnt_ff <= div_ff;
		end else begin
			tick_cnt_ff <= tick_cnt_ff - 8'h01;
		end
	end

	// Pending word holder, one deep, stalls nothing
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pend_ff      <= 1'b0;
			pend_word_ff <= 16'h0000;
		end else if (wr_data) begin
			pend_ff      <= 1'b1;
			pend_word_ff <= src_word;
		end else if (state_ff == ST_IDLE && pend_ff) begin
			pend_ff <= 1'b0;
		end
	end

	// Transfer sequencer
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff           <= ST_IDLE;
			shift_ff           <= 16'h0000;
			bit_cnt_ff         <= 5'h00;
			hold_cnt_ff        <= 8'h00;
			busy_ff            <= 1'b0;
			frame_sync_n       <= 1'b1;
			serial_clock_input <= 1'b0;
			serial_data_input  <= 1'b0;
			load_outputs_n     <= 1'b1;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				if (pend_ff) begin
					// MSB first, frame low before the first falling clock edge
					shift_ff           <= pend_word_ff;
					frame_sync_n       <= 1'b0;
					// Word mode raises the clock in the same cycle that frame falls
					serial_clock_input <= ctrl_ff[`QDL_CTRL_WORD_MODE];
					bit_cnt_ff         <= 5'h00;
					busy_ff            <= 1'b1;
					state_ff           <= ST_SETUP;
				end else if (reg_wr && reg_addr == `QDL_REG_STROBE &&
					reg_wdata[`QDL_STB_LOAD]) begin
					load_outputs_n <= 1'b0;
					hold_cnt_ff    <= `QDL_STROBE_CYC;
					busy_ff        <= 1'b1;
					state_ff       <= ST_LOAD;
				end
			end
			ST_SETUP: begin
				if (tick) begin
					if (ctrl_ff[`QDL_CTRL_WORD_MODE]) begin
						// Data changes on rising edge, device samples at fall
						serial_clock_input <= 1'b1;
					end else begin
						serial_clock_input <= 1'b0;
					end
					serial_data_input <= shift_ff[15];
					shift_ff          <= {shift_ff[14:0], 1'b0};
					state_ff          <= ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (tick) begin
					serial_clock_input <= 1'b1;
					state_ff           <= ST_LOW;
				end
			end
			ST_LOW: begin
				if (tick) begin
					// Falling edge, data held stable across it
					serial_clock_input <= 1'b0;
					bit_cnt_ff         <= bit_cnt_ff + 5'h01;
					if (bit_cnt_ff + 5'h01 == `QDL_WORD_BITS) begin
						state_ff <= ST_DONE;
					end else if (bit_cnt_ff + 5'h01 == `QDL_BYTE_BITS &&
						!ctrl_ff[`QDL_CTRL_WORD_MODE]) begin
						// Frame stays low between the two bytes
						hold_cnt_ff <= `QDL_GAP_CYC;
						state_ff    <= ST_GAP;
					end else begin
						state_ff <= ST_SETUP;
					end
				end
			end
			ST_GAP: begin
				if (hold_cnt_ff == 8'h00) begin
					state_ff <= ST_SETUP;
				end else begin
					hold_cnt_ff <= hold_cnt_ff - 8'h01;
				end
			end
			ST_DONE: begin
				if (tick) begin
					// End of frame after the last bit
					frame_sync_n       <= 1'b1;
					serial_clock_input <= 1'b0;
					if (ctrl_ff[`QDL_CTRL_AUTO_LOAD]) begin
						load_outputs_n <= 1'b0;
						hold_cnt_ff    <= `QDL_STROBE_CYC;
						state_ff       <= ST_LOAD;
					end else begin
						busy_ff  <= 1'b0;
						state_ff <= ST_IDLE;
					end
				end
			end
			ST_LOAD: begin
				if (hold_cnt_ff == 8'h00) begin
					load_outputs_n <= 1'b1;
					busy_ff        <= 1'b0;
					state_ff       <= ST_IDLE;
				end else begin
					hold_cnt_ff <= hold_cnt_ff - 8'h01;
				end
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

endmodule

//--- verification/qdl_host_loader_sva.sv
// Pin assertions for the loader
`timescale 1ns/1ps
module qdl_host_loader_sva (
	input wire logic        clock, rst, reg_wr, reg_rd, frame_sync_n, serial_clock_input,
	input wire logic        serial_data_input, load_outputs_n, clear_outputs_n,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata, reg_rdata
);
	logic [4:0] n_ff;
	always @(posedge clock or posedge rst) begin
		if (rst || frame_sync_n)
			n_ff <= 5'h0;
		else if ($fell(serial_clock_input))
			n_ff <= n_ff + 5'h1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_ld_low;
		!load_outputs_n[*8] ##1 !load_outputs_n ##1 load_outputs_n;
	endsequence
	a_data_stable: assert property ($fell(serial_clock_input) |-> $stable(serial_data_input))
		else $error("data moved at clock fall");
	a_clk_framed: assert property ($fell(serial_clock_input) |-> !frame_sync_n)
		else $error("clock edge outside frame");
	a_word_bits: assert property ($rose(frame_sync_n) |-> n_ff == 5'h10)
		else $error("frame not sixteen bits");
	a_end_clk_low: assert property ($rose(frame_sync_n) |-> !serial_clock_input)
		else $error("clock high at frame end");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside slot");
	a_bad_addr: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0)
		else $error("unmapped read not zero");
	a_load_width: assert property ($fell(load_outputs_n) |-> s_ld_low)
		else $error("load pulse width");
	a_load_idle: assert property (!load_outputs_n |-> frame_sync_n)
		else $error("load inside frame");
endmodule
bind qdl_host_loader qdl_host_loader_sva u_sva (.*);

//--- verification/qdl_dev_model.sv
// Behavioural quad converter seen at its serial pins
`timescale 1ns/1ps
module qdl_dev_model (
	input wire logic frame_sync_n, serial_clock_input, serial_data_input,
	input wire logic load_outputs_n, clear_outputs_n, device_addr_bit_hi, device_addr_bit_lo
);
	logic [15:0] sh, wd;
	logic [11:0] in_l[4], out_l[4];
	int          n = 0, acc = 0;
	always @(negedge frame_sync_n) n = 0;
	always @(negedge serial_clock_input) begin
		if (!frame_sync_n) begin
			sh = {sh[14:0], serial_data_input};
			n++;
			if (n == 16 && sh[3:2] == {device_addr_bit_hi, device_addr_bit_lo}) begin
				in_l[sh[1:0]] = sh[15:4];
				wd = sh;
				acc++;
			end
		end
	end
	always @(load_outputs_n, clear_outputs_n, acc) begin
		if (!clear_outputs_n)
			out_l = '{default: 12'h0};
		else if (!load_outputs_n)
			out_l = in_l;
	end
endmodule

//--- verification/qdl_host_loader_tb.sv
// Self-checking bench for the loader
`timescale 1ns/1ps
module qdl_host_loader_tb;
	logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic        device_addr_bit_hi = 1, device_addr_bit_lo = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0, reg_rdata, w;
	logic        frame_sync_n, serial_clock_input, serial_data_input;
	logic        load_outputs_n, clear_outputs_n;
	logic [11:0] el[4];
	logic [15:0] q[$];
	int          errors = 0, checks_done = 0, i;
	qdl_host_loader u_dut (.*);
	qdl_dev_model u_dev (.*);
	initial forever #2.5 clock = ~clock;
	task chk(input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	function logic [7:0] rv(input logic [7:0] b);
		for (int j = 0; j < 8; j++)
			rv[j] = b[7 - j];
	endfunction
	// Word with own address if ok, optionally bit-reversed within each byte for an LSB-first source
	task send(input logic [1:0] ch, input logic ok, rev);
		int k;
		w = $urandom;
		w[3:0] = {ok ? 2'b10 : 2'b01, ch};
		if (ok) begin
			q.push_back(w);
			el[ch] = w[15:4];
		end
		wr(4'h0, rev ? {rv(w[15:8]), rv(w[7:0])} : w);
		repeat (3) @(posedge clock);
		chk(frame_sync_n, 1'b0);
		for (k = 0; k < 400 && frame_sync_n !== 1'b1; k++)
			@(posedge clock);
		chk(frame_sync_n, 1'b1);
		repeat (16) @(posedge clock);
	endtask
	task outs(input logic on);
		for (i = 0; i < 4; i++)
			chk({4'h0, u_dev.out_l[i]}, on ? {4'h0, el[i]} : 16'h0);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial forever @(u_dev.acc) chk(u_dev.wd, q.pop_front());
	initial begin
		#40000;
		errors++;
		complete_run;
	end
	initial begin
		void'($urandom(95));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		rd(4'h1, 16'h0);
		rd(4'h3, 16'h0003);
		rd(4'h2, 16'h0006);
		rd(4'hf, 16'h0);
		$display("test reset done");
		for (int c = 0; c < 4; c++)
			send(c[1:0], 1, 0);
		send(2'h1, 0, 0);
		wr(4'h4, 16'h0001);
		repeat (16) @(posedge clock);
		outs(1);
		wr(4'h4, 16'h0002);
		repeat (4) @(posedge clock);
		outs(0);
		repeat (4) @(posedge clock);
		chk(clear_outputs_n, 1'b1);
		$display("test byte done");
		wr(4'h1, 16'h0001);
		send(2'h1, 1, 0);
		send(2'h2, 1, 0);
		wr(4'h1, 16'h0006);
		send(2'h3, 1, 1);
		outs(1);
		$display("test word done");
		chk(q.size(), 16'h0);
		complete_run;
	end
endmodule
